// *** pkg/twi_status_defs.svh ***
// offsets, field positions, reset values and timing counts of the two-wire status block
`ifndef TWI_STATUS_DEFS_SVH
`define TWI_STATUS_DEFS_SVH
`define TWI_CONTROL_OFS     8'hc0
`define TWI_STATUS_OFS     8'hc1
`define TWI_TIMEOUT_OFS    8'hc2
`define TWI_CONTROL_RST    8'h00
`define TWI_TIMEOUT_RST    8'h00
`define CTL_HOLDEXT_BIT    7
`define CTL_BUSEN_BIT      6
`define CTL_BEGIN_BIT      5
`define CTL_HALT_BIT       4
`define CTL_EVENT_BIT      3
`define CTL_ACK_BIT        2
`define CTL_SWAP_BIT       0
`define TO_ENABLE_BIT      0
`define TO_PRESCALE_LSB    1
`define TO_FLAG_BIT        7
`define TO_WIDTH           14
`define HOLD_EXT_CLKS      4'h8
`define UNJAM_HALF_CLKS    6'h14
`define ST_BUS_ERROR       8'h00
`define ST_START           8'h08
`define ST_RESTART         8'h10
`define ST_MT_ADDR_ACK     8'h18
`define ST_MT_ADDR_NACK    8'h20
`define ST_MT_DATA_ACK     8'h28
`define ST_MT_DATA_NACK    8'h30
`define ST_ARB_LOST        8'h38
`define ST_MR_ADDR_ACK     8'h40
`define ST_MR_ADDR_NACK    8'h48
`define ST_MR_DATA_ACK     8'h50
`define ST_MR_DATA_NACK    8'h58
`define ST_SR_ADDR_ACK     8'h60
`define ST_SR_ARB_LOST     8'h68
`define ST_GC_ADDR_ACK     8'h70
`define ST_GC_ARB_LOST     8'h78
`define ST_SR_DATA_ACK     8'h80
`define ST_SR_DATA_NACK    8'h88
`define ST_GC_DATA_ACK     8'h90
`define ST_GC_DATA_NACK    8'h98
`define ST_ST_STOP         8'ha0
`define ST_ST_ADDR_ACK     8'ha8
`define ST_ST_ARB_LOST     8'hb0
`define ST_ST_DATA_ACK     8'hb8
`define ST_ST_DATA_NACK    8'hc0
`define ST_ST_LAST_ACK     8'hc8
`define ST_IDLE            8'hf8
`endif

// *** pkg/twi_status_pkg.sv ***
// types of the two-wire status block
package twi_status_pkg;
   typedef enum logic [3:0] {
      ST_OFF     = 4'b0001,
      ST_READY   = 4'b0010,
      ST_UNJAM   = 4'b0100,
      ST_BUSERR  = 4'b1000
   } phase_t;

   typedef struct packed {
      phase_t      phase;
      logic [7:0]  control;
      logic [7:0]  status;
      logic [2:0]  toCfg;
      logic        toFlag;
      logic [13:0] toCount;
      logic [7:0]  toPre;
      logic [7:0]  rdata;
      logic [1:0]  sdaSync;
      logic [1:0]  sclSync;
      logic        sdaPrev;
      logic        sclPrev;
      logic [3:0]  bitCnt;
      logic        frame;
      logic        master;
      logic [5:0]  pulseDiv;
      logic        pulseLow;
      logic [3:0]  holdCnt;
      logic        sdaDrive;
   } state_t;
endpackage

// *** test/twi_bus_model.sv ***
// other parties on the two-wire bus: pull-ups, an out-of-step slave and a foreign master
`timescale 1ns/100ps

module twi_bus_model (
   input  wire logic dutSdaOe, // device pulls data low
   input  wire logic dutSclOe, // device pulls clock low
   output logic      sdaLine,  // resolved data level
   output logic      sclLine   // resolved clock level
);
   logic sdaLow = 1'b0;
   logic sclLow = 1'b0;
   int   falls  = 0;

   // pull-ups: a released line reads high, never a stale value
   assign sdaLine = ~(dutSdaOe | sdaLow);
   assign sclLine = ~(dutSclOe | sclLow);

   always @(negedge sclLine) begin
      falls++;
   end

   // foreign master timing at a 125 ns link period; clock stands still between frames
   task automatic start_cond();
      sdaLow = 1'b1;
      #62.5;
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         sclLow = 1'b1;
         #62.5;
         sclLow = 1'b0;
         #62.5;
      end
   endtask

   task automatic stop_cond();
      sdaLow = 1'b0;
      #125;
   endtask

   // a slave out of bit step keeps data low until it has seen n clock falls
   task automatic jam(input int n);
      int f0;
      f0 = falls;
      sdaLow = 1'b1;
      wait (falls >= f0 + n);
      #30;
      sdaLow = 1'b0;
   endtask
endmodule

// *** test/twi_status_error_timeout_tb_top.sv ***
// self-checking bench of the two-wire status, bus-error and time-out block
`timescale 1ns/100ps
`include "twi_status_defs.svh"

module twi_status_error_timeout_tb_top;
   import twi_status_pkg::*;
   logic       clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0, swap = 1'b0;
   logic       portIrqMaskBit = 1'b0, globalIrqEnable = 1'b0, statusValid = 1'b0;
   logic       masterMode = 1'b0, startReq = 1'b0, engineSdaOe = 1'b0, engineSclOe = 1'b0;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, statusIn = 8'h00, regRdata;
   logic       irqReq, startDone, pinAOut, pinAOe, pinBOut, pinBOe, sdaLine, sclLine;
   int         miscompares = 0, check_count = 0, cycles = 0, n = 0, lat[2];
   logic [7:0] codes[$] = '{8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48,
      8'h50, 8'h58, 8'h60, 8'h68, 8'h70, 8'h78, 8'h80, 8'h88, 8'h90, 8'h98, 8'ha0, 8'ha8,
      8'hb0, 8'hb8, 8'hc0, 8'hc8};

   twi_status_error_timeout u_dut (.clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead,
      .regRdata, .portIrqMaskBit, .globalIrqEnable, .irqReq, .statusValid, .statusIn,
      .masterMode, .startReq, .startDone, .engineSdaOe, .engineSclOe,
      .pinAIn(swap ? sclLine : sdaLine), .pinAOut, .pinAOe,
      .pinBIn(swap ? sdaLine : sclLine), .pinBOut, .pinBOe);

   twi_bus_model u_bus (.dutSdaOe(swap ? pinBOe : pinAOe), .dutSclOe(swap ? pinAOe : pinBOe),
      .sdaLine, .sclLine);

   initial begin
      forever #2 clk = ~clk;
   end

   // hang guard: the whole sequence needs about 37500 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rchk(input string what, input logic [7:0] a, exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      chk(what, regRdata, exp);
   endtask

   task automatic post(input logic [7:0] c, input logic m, g);
      @(posedge clk);
      statusValid     <= 1'b1;
      statusIn        <= c;
      portIrqMaskBit  <= m;
      globalIrqEnable <= g;
      @(posedge clk);
      statusValid <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   initial begin
      void'($urandom(47566));
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rchk("control", `TWI_CONTROL_OFS, 8'h00);
      rchk("status", `TWI_STATUS_OFS, 8'hf8);
      rchk("timeout cfg", `TWI_TIMEOUT_OFS, 8'h00);
      rchk("unmapped", 8'h10, 8'h00);
      post(8'h18, 1'b1, 1'b1);
      rchk("status off", `TWI_STATUS_OFS, 8'hf8);
      chk("irq off", {7'h00, irqReq}, 8'h00);
      $display("test reset done");
      wr(`TWI_CONTROL_OFS, 8'h42);
      rchk("control", `TWI_CONTROL_OFS, 8'h40);
      foreach (codes[i]) begin
         post(codes[i], 1'($urandom), 1'($urandom));
         rchk("status", `TWI_STATUS_OFS, codes[i]);
         chk("irq", {7'h00, irqReq}, {7'h00, portIrqMaskBit & globalIrqEnable});
         chk("clock held", {7'h00, sclLine}, 8'h00);
         chk("pad b oe", {7'h00, pinBOe}, 8'h01);
         wr(`TWI_CONTROL_OFS, 8'h40);
         chk("irq cleared", {7'h00, irqReq}, 8'h00);
      end
      post(8'hf8, 1'b1, 1'b1);
      rchk("status idle", `TWI_STATUS_OFS, 8'hf8);
      chk("irq idle", {7'h00, irqReq}, 8'h00);
      $display("test status codes done");
      wr(`TWI_CONTROL_OFS, 8'h41);
      swap = 1'b1;
      post(8'h08, 1'b1, 1'b1);
      chk("swapped oe", {6'h00, pinAOe, pinBOe}, 8'h02);
      wr(`TWI_CONTROL_OFS, 8'h41);
      wr(`TWI_CONTROL_OFS, 8'h40);
      swap = 1'b0;
      $display("test pin swap done");
      for (int m = 0; m < 2; m++) begin
         fork
            u_bus.jam(3);
         join_none
         @(posedge clk);
         masterMode <= 1'(m);
         startReq   <= 1'b1;
         n = 0;
         while (startDone !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
         end
         chk("start done", {7'h00, startDone}, 8'h01);
         chk("jam released", {7'h00, u_bus.sdaLow}, 8'h00);
         @(posedge clk);
         startReq <= 1'b0;
         rchk("status", `TWI_STATUS_OFS, 8'h08);
         wr(`TWI_CONTROL_OFS, 8'h40);
      end
      $display("test unjam done");
      wr(`TWI_CONTROL_OFS, 8'h50);
      u_bus.start_cond();
      u_bus.stop_cond();
      repeat (10) @(posedge clk);
      rchk("halt cleared", `TWI_CONTROL_OFS, 8'h40);
      $display("test halt on stop done");
      u_bus.start_cond();
      u_bus.pulses(4);
      u_bus.stop_cond();
      repeat (10) @(posedge clk);
      rchk("status", `TWI_STATUS_OFS, 8'h00);
      rchk("control", `TWI_CONTROL_OFS, 8'h48);
      chk("released", {6'h00, pinAOe, pinBOe}, 8'h00);
      chk("pad levels", {6'h00, pinAOut, pinBOut}, 8'h00);
      wr(`TWI_CONTROL_OFS, 8'h58);
      wr(`TWI_CONTROL_OFS, 8'h50);
      rchk("control", `TWI_CONTROL_OFS, 8'h40);
      rchk("status", `TWI_STATUS_OFS, 8'hf8);
      chk("no stop driven", {7'h00, pinAOe}, 8'h00);
      $display("test bus error done");
      for (int h = 0; h < 2; h++) begin
         wr(`TWI_CONTROL_OFS, h ? 8'hc0 : 8'h40);
         @(posedge clk);
         engineSclOe <= 1'b1;
         // data moves only after the clock fall has passed the synchroniser
         repeat (3) @(posedge clk);
         engineSdaOe <= 1'b1;
         n = 0;
         while (pinAOe !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
         end
         lat[h] = n;
         @(posedge clk);
         engineSdaOe <= 1'b0;
         engineSclOe <= 1'b0;
         repeat (30) @(posedge clk);
      end
      chk("hold extension", 8'(lat[1] - lat[0]), 8'h08);
      $display("test hold extension done");
      wr(`TWI_CONTROL_OFS, 8'h40);
      wr(`TWI_TIMEOUT_OFS, 8'h01);
      repeat (10000) @(posedge clk);
      post(8'h28, 1'b1, 1'b1);
      repeat (10000) @(posedge clk);
      rchk("timeout held", `TWI_TIMEOUT_OFS, 8'h01);
      wr(`TWI_CONTROL_OFS, 8'h40);
      repeat (16000) @(posedge clk);
      rchk("timeout early", `TWI_TIMEOUT_OFS, 8'h01);
      repeat (600) @(posedge clk);
      rchk("timeout flag", `TWI_TIMEOUT_OFS, 8'h81);
      chk("timeout irq", {7'h00, irqReq}, 8'h01);
      wr(`TWI_TIMEOUT_OFS, 8'h00);
      chk("timeout irq off", {7'h00, irqReq}, 8'h00);
      $display("test timeout done");
      stop_test();
   end
endmodule

// *** verilog/twi_status_error_timeout.sv ***
// status, bus-error, unjam and time-out logic of the two-wire serial port
`timescale 1ns/100ps
`include "twi_status_defs.svh"

module twi_status_error_timeout
   import twi_status_pkg::*;
(
   input  wire logic       clk,             // system clock, 250 MHz
   input  wire logic       resetn,          // asynchronous reset, active low
   input  wire logic [7:0] regAddr,         // register address
   input  wire logic [7:0] regWdata,        // register write data
   input  wire logic       regWrite,        // write strobe
   input  wire logic       regRead,         // read strobe
   output logic      [7:0] regRdata,        // read data, cycle after the strobe
   input  wire logic       portIrqMaskBit,  // port interrupt mask
   input  wire logic       globalIrqEnable, // global interrupt enable
   output logic            irqReq,          // shared interrupt request
   input  wire logic       statusValid,     // protocol engine reports a new status
   input  wire logic [7:0] statusIn,        // status code from protocol engine
   input  wire logic       masterMode,      // protocol engine owns the bus as master
   input  wire logic       startReq,        // engine wants a START or repeated START
   output logic            startDone,       // pulse: START placed after recovery
   input  wire logic       engineSdaOe,     // engine pulls data low
   input  wire logic       engineSclOe,     // engine pulls clock low
   input  wire logic       pinAIn,          // pad A level
   output logic            pinAOut,         // pad A output, always 0
   output logic            pinAOe,          // pad A pull-low enable
   input  wire logic       pinBIn,          // pad B level
   output logic            pinBOut,         // pad B output, always 0
   output logic            pinBOe           // pad B pull-low enable
);
   state_t r;
   state_t next_r;

   logic sda;
   logic scl;
   logic sdaFall;
   logic sdaRise;
   logic sclRise;
   logic startSeen;
   logic stopSeen;
   logic eventFlag;
   logic enabled;
   logic sdaWant;
   logic sclWant;
   logic toTick;
   logic errHit;

   assign sda       = r.sdaSync[1];
   assign scl       = r.sclSync[1];
   assign sdaFall   = r.sdaPrev & ~sda;
   assign sdaRise   = ~r.sdaPrev & sda;
   assign sclRise   = ~r.sclPrev & scl;
   assign startSeen = sdaFall & scl & r.sclPrev;
   assign stopSeen  = sdaRise & scl & r.sclPrev;
   assign eventFlag = r.control[`CTL_EVENT_BIT];
   assign enabled   = r.control[`CTL_BUSEN_BIT];
   assign toTick    = (r.toPre == 8'h00);
   assign errHit    = r.frame & (r.bitCnt >= 4'h2) & (r.bitCnt <= 4'h8) &
                      (startSeen | stopSeen);

   always_comb begin
      next_r = r;
      next_r.rdata = 8'h00;
      startDone = 1'b0;
      // pin swap is applied at the synchroniser input so all logic sees one view
      next_r.sdaSync = {r.sdaSync[0], r.control[`CTL_SWAP_BIT] ? pinBIn : pinAIn};
      next_r.sclSync = {r.sclSync[0], r.control[`CTL_SWAP_BIT] ? pinAIn : pinBIn};
      next_r.sdaPrev = sda;
      next_r.sclPrev = scl;

      // register writes
      if (regWrite) begin
         if (regAddr == `TWI_CONTROL_OFS) begin
            next_r.control = regWdata & 8'hfd;
            // software may only clear the event flag; hardware sets it
            next_r.control[`CTL_EVENT_BIT] = eventFlag & regWdata[`CTL_EVENT_BIT];
         end else if (regAddr == `TWI_TIMEOUT_OFS) begin
            next_r.toCfg  = regWdata[2:0];
            next_r.toFlag = r.toFlag & regWdata[`TO_FLAG_BIT];
         end
      end
      if (regRead) begin
         if (regAddr == `TWI_CONTROL_OFS) begin
            next_r.rdata = r.control;
         end else if (regAddr == `TWI_STATUS_OFS) begin
            next_r.rdata = r.status;
         end else if (regAddr == `TWI_TIMEOUT_OFS) begin
            next_r.rdata = {r.toFlag, 4'h0, r.toCfg};
         end
      end

      // bit position inside a byte, for bus error detection
      if (startSeen | stopSeen) begin
         next_r.frame  = startSeen;
         next_r.bitCnt = 4'h0;
      end else if (sclRise & r.frame) begin
         next_r.bitCnt = (r.bitCnt == 4'h8) ? 4'h0 : r.bitCnt + 4'h1;
      end
      next_r.master = masterMode;

      // halt request self-clears on STOP seen as master
      if (stopSeen & r.master) begin
         next_r.control[`CTL_HALT_BIT] = 1'b0;
      end

      // hold extension counter, restarted on each falling clock edge
      if (r.sclPrev & ~scl & r.control[`CTL_HOLDEXT_BIT]) begin
         next_r.holdCnt = `HOLD_EXT_CLKS;
      end else if (r.holdCnt != 4'h0) begin
         next_r.holdCnt = r.holdCnt - 4'h1;
      end
      if (r.holdCnt == 4'h0) begin
         next_r.sdaDrive = engineSdaOe;
      end

      case (r.phase)
         ST_OFF: begin
            next_r.status = `ST_IDLE;
            if (enabled) begin
               next_r.phase = ST_READY;
            end
         end
         ST_READY: begin
            if (statusValid) begin
               next_r.status = statusIn;
               next_r.control[`CTL_EVENT_BIT] = (statusIn != `ST_IDLE);
            end
            if (errHit) begin
               next_r.phase  = ST_BUSERR;
               next_r.status = `ST_BUS_ERROR;
               next_r.control[`CTL_EVENT_BIT] = 1'b1;
               next_r.frame  = 1'b0;
            end else if (startReq & ~sda & scl & ~eventFlag) begin
               next_r.phase    = ST_UNJAM;
               next_r.pulseDiv = `UNJAM_HALF_CLKS;
               next_r.pulseLow = 1'b1;
            end
         end
         ST_UNJAM: begin
            if (r.pulseDiv == 6'h00) begin
               next_r.pulseDiv = `UNJAM_HALF_CLKS;
               next_r.pulseLow = ~r.pulseLow;
               if (~r.pulseLow & sda) begin
                  // released: a START follows, reported as 08 even for a repeat
                  next_r.phase  = ST_READY;
                  // the START placed here opens a new frame at bit zero, so the
                  // recovery pulses are not taken as bits of the next byte
                  next_r.frame  = 1'b1;
                  next_r.bitCnt = 4'h0;
                  next_r.status = `ST_START;
                  next_r.control[`CTL_EVENT_BIT] = 1'b1;
                  next_r.pulseLow = 1'b0;
                  startDone = 1'b1;
               end
            end else begin
               next_r.pulseDiv = r.pulseDiv - 6'h01;
            end
         end
         ST_BUSERR: begin
            if (r.control[`CTL_HALT_BIT] & ~eventFlag) begin
               next_r.control[`CTL_HALT_BIT] = 1'b0;
               next_r.status = `ST_IDLE;
               next_r.phase  = ST_READY;
            end
         end
         default: begin
            next_r.phase = ST_OFF;
         end
      endcase
      if (~enabled) begin
         next_r.phase = ST_OFF;
         next_r.frame = 1'b0;
      end

      // time-out counter on a prescaled system clock
      next_r.toPre = toTick ? {r.toCfg[2:1], 6'h00} >> 6 : r.toPre - 8'h01;
      if (~r.toCfg[`TO_ENABLE_BIT] | eventFlag) begin
         next_r.toCount = 14'h0000;
      end else if (toTick) begin
         next_r.toCount = r.toCount + 14'h0001;
         if (r.toCount == 14'h3fff) begin
            next_r.toFlag = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r          <= '0;
         r.phase    <= ST_OFF;
         r.control  <= `TWI_CONTROL_RST;
         r.status   <= `ST_IDLE;
         r.sdaSync  <= 2'b11;
         r.sclSync  <= 2'b11;
         r.sdaPrev  <= 1'b1;
         r.sclPrev  <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // bus error releases both lines; event flag holds clock low in the ready phase
   always_comb begin
      sdaWant = 1'b0;
      sclWant = 1'b0;
      if (r.phase == ST_READY) begin
         sdaWant = r.sdaDrive;
         sclWant = engineSclOe | eventFlag;
      end else if (r.phase == ST_UNJAM) begin
         sclWant = r.pulseLow;
      end
   end

   assign pinAOut  = 1'b0;
   assign pinBOut  = 1'b0;
   assign pinAOe   = r.control[`CTL_SWAP_BIT] ? sclWant : sdaWant;
   assign pinBOe   = r.control[`CTL_SWAP_BIT] ? sdaWant : sclWant;
   assign regRdata = r.rdata;
   assign irqReq   = (eventFlag | r.toFlag) & portIrqMaskBit & globalIrqEnable;

   // assertions
   sequence errSeen_s;
      r.phase == ST_READY && r.frame && r.bitCnt >= 4'h2 && r.bitCnt <= 4'h8
         && (startSeen || stopSeen);
   endsequence
   sequence errLoaded_s;
      r.status == `ST_BUS_ERROR && eventFlag && r.phase == ST_BUSERR;
   endsequence

   bus_error_a: assert property (@(posedge clk) disable iff (!resetn)
      (errSeen_s and enabled) |=> errLoaded_s) else $error("bus error not flagged");
   error_release_a: assert property (@(posedge clk) disable iff (!resetn)
      r.phase == ST_BUSERR |-> !pinAOe && !pinBOe) else $error("lines held in bus error");
   error_exit_a: assert property (@(posedge clk) disable iff (!resetn)
      r.phase == ST_BUSERR && r.control[`CTL_HALT_BIT] && !eventFlag && enabled
      |=> r.phase == ST_READY && !r.control[`CTL_HALT_BIT] && r.status == `ST_IDLE)
      else $error("bus error exit wrong");
   idle_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      r.phase == ST_OFF |=> !$rose(eventFlag)) else $error("event set while idle");
   unjam_start_a: assert property (@(posedge clk) disable iff (!resetn)
      startDone |=> r.status == `ST_START && eventFlag) else $error("unjam status not 08");
   stretch_a: assert property (@(posedge clk) disable iff (!resetn)
      r.phase == ST_READY && eventFlag |-> (r.control[`CTL_SWAP_BIT] ? pinAOe : pinBOe))
      else $error("clock not held low");
   timeout_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      eventFlag |=> r.toCount == 14'h0000) else $error("counter ran with event set");
   timeout_flag_a: assert property (@(posedge clk) disable iff (!resetn)
      r.toCfg[`TO_ENABLE_BIT] && !eventFlag && toTick && r.toCount == 14'h3fff
      |=> r.toFlag && r.toCount == 14'h0000) else $error("overflow missed");
   irq_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      r.toFlag && portIrqMaskBit && globalIrqEnable |-> irqReq) else $error("irq lost");
   halt_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      stopSeen && r.master && !regWrite |=> !r.control[`CTL_HALT_BIT])
      else $error("halt request kept after stop");
   hold_ext_a: assert property (@(posedge clk) disable iff (!resetn)
      r.holdCnt == 4'h8 |-> ##1 r.holdCnt == 4'h7 ##7 r.holdCnt == 4'h0)
      else $error("hold extension length wrong");
   hold_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      r.holdCnt == 4'h0 |=> r.sdaDrive == $past(engineSdaOe))
      else $error("data drive not following engine");
   hold_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      r.holdCnt != 4'h0 |=> $stable(r.sdaDrive))
      else $error("data drive moved inside hold window");

   // disabled port stays quiet
   disable_off_a: assert property (@(posedge clk) disable iff (!resetn)
      !enabled |=> r.phase == ST_OFF)
      else $error("phase not off while disabled");
   off_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      r.phase == ST_OFF |-> !pinAOe && !pinBOe)
      else $error("lines driven while disabled");
   off_status_a: assert property (@(posedge clk) disable iff (!resetn)
      r.phase == ST_OFF |=> r.status == `ST_IDLE)
      else $error("status not idle while disabled");

   // status codes posted by the protocol engine
   sequence codeIn_s;
      r.phase == ST_READY && enabled && statusValid && !errHit;
   endsequence
   status_load_a: assert property (@(posedge clk) disable iff (!resetn)
      codeIn_s |=> r.status == $past(statusIn))
      else $error("status code not loaded");
   event_raise_a: assert property (@(posedge clk) disable iff (!resetn)
      (codeIn_s and statusIn != `ST_IDLE) |=> eventFlag)
      else $error("event flag not raised");
   idle_code_a: assert property (@(posedge clk) disable iff (!resetn)
      (codeIn_s and statusIn == `ST_IDLE && !eventFlag) |=> !eventFlag)
      else $error("idle code raised event");
   error_wait_a: assert property (@(posedge clk) disable iff (!resetn)
      r.phase == ST_BUSERR && eventFlag && enabled |=> r.phase == ST_BUSERR)
      else $error("bus error left before flag cleared");
   event_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      regWrite && regAddr == `TWI_CONTROL_OFS && !regWdata[`CTL_EVENT_BIT]
      && (r.phase == ST_OFF || r.phase == ST_BUSERR) |=> !eventFlag)
      else $error("event flag not cleared");

   // stuck data line recovery, entry, pulses and exit
   sequence jamSeen_s;
      r.phase == ST_READY && enabled && !errHit && startReq && !sda && scl && !eventFlag;
   endsequence
   sequence jamGone_s;
      r.phase == ST_UNJAM && enabled && r.pulseDiv == 6'h00 && !r.pulseLow && sda;
   endsequence
   unjam_enter_a: assert property (@(posedge clk) disable iff (!resetn)
      jamSeen_s |=> r.phase == ST_UNJAM && r.pulseLow)
      else $error("recovery not started");
   unjam_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
      r.phase == ST_UNJAM |-> (r.control[`CTL_SWAP_BIT] ? pinAOe : pinBOe) == r.pulseLow)
      else $error("recovery clock wrong");
   unjam_data_a: assert property (@(posedge clk) disable iff (!resetn)
      r.phase == ST_UNJAM |-> !(r.control[`CTL_SWAP_BIT] ? pinBOe : pinAOe))
      else $error("data driven during recovery");
   unjam_exit_a: assert property (@(posedge clk) disable iff (!resetn)
      jamGone_s |-> startDone ##1 r.phase == ST_READY && r.status == `ST_START)
      else $error("recovery did not end");

   // time-out counter and shared interrupt
   timeout_step_a: assert property (@(posedge clk) disable iff (!resetn)
      r.toCfg[`TO_ENABLE_BIT] && !eventFlag && toTick
      |=> r.toCount == $past(r.toCount) + 14'h0001)
      else $error("time-out counter did not step");
   timeout_off_a: assert property (@(posedge clk) disable iff (!resetn)
      !r.toCfg[`TO_ENABLE_BIT] |=> r.toCount == 14'h0000)
      else $error("time-out counter ran while off");
   flag_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      regWrite && regAddr == `TWI_TIMEOUT_OFS && !regWdata[`TO_FLAG_BIT]
      && r.toCount != 14'h3fff |=> !r.toFlag)
      else $error("time-out flag not cleared");
   irq_mask_a: assert property (@(posedge clk) disable iff (!resetn)
      !(portIrqMaskBit && globalIrqEnable) |-> !irqReq)
      else $error("interrupt not masked");
   irq_event_a: assert property (@(posedge clk) disable iff (!resetn)
      eventFlag && portIrqMaskBit && globalIrqEnable |-> irqReq)
      else $error("event interrupt lost");
endmodule
